/* File: ftx_pkg.sv */
// Shared constants and carriers for the 10 MHz line-clock transmit coder and receive decoder
package ftx_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SYM_BITS = 5;
  localparam int unsigned NIB_BITS = 4;
  localparam int unsigned LFSR_BITS = 11;
  localparam int unsigned ADDR_BITS = 5;
  localparam logic [2:0] SLOT_LAST = 3'h4;
  localparam logic [2:0] SEED_SETTLE = 3'h3;
  // Control code-groups, receive start nibbles and MLT-3 line levels
  localparam logic [4:0] C_IDLE = 5'h1F;
  localparam logic [4:0] C_J = 5'h18;
  localparam logic [4:0] C_K = 5'h11;
  localparam logic [4:0] C_T = 5'h0D;
  localparam logic [4:0] C_R = 5'h07;
  localparam logic [4:0] C_H = 5'h04;
  localparam logic [4:0] C_P = 5'h00;
  localparam logic [3:0] NIB_SSD = 4'h5;
  localparam logic [3:0] NIB_BAD_SSD = 4'hE;
  localparam logic [1:0] MLT_ZERO = 2'h0;
  localparam logic [1:0] MLT_POS = 2'h1;
  localparam logic [1:0] MLT_NEG = 2'h3;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_J = 3'h1,
    TX_K = 3'h3,
    TX_DATA = 3'h2,
    TX_T = 3'h6,
    TX_R = 3'h7
  } ftx_tx_st_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_GOT_J = 2'h1,
    RX_DATA = 2'h3,
    RX_GOT_T = 2'h2
  } ftx_rx_st_e;

  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] d;
  } ftx_mii_tx_s;

  typedef struct packed {
    logic dv;
    logic er;
    logic crs;
    logic [3:0] d;
  } ftx_mii_rx_s;

  typedef struct packed {
    logic ok;
    logic [3:0] nib;
  } ftx_dec_s;
endpackage : ftx_pkg

/* File: ftx_coder.sv */
// 4B/5B coder, scrambler, NRZI and MLT-3 line encoder, plus 5B/4B receive decoder
// Overview of operation
// RULE_01: Each data nibble 0..F maps to its fixed five-bit code-group.
// RULE_02: MAC supplies nibbles with transmit enable high while data is valid.
// RULE_03: After the end pair, IDLE 11111 repeats until transmit enable rises.
// RULE_04: Rising transmit enable sends /J/ then /K/ instead of preamble nibbles.
// RULE_05: Falling transmit enable sends /T/ then /R/.
// RULE_06: Received /J/ is the first start nibble and yields 0101.
// RULE_07: Received /K/ yields 0101 only right after /J/, else receive error.
// RULE_08: /T/ then /R/ ends stream; lone /T/ or lone /R/ flags error.
// RULE_09: Invalid code-groups are never sent and flag error during valid data.
// RULE_10: Low-power idle sends sleep code-group 00000, also as refresh.
// RULE_11: Received 00000 signals the far end is entering low-power idle.
// RULE_12: Scrambler seed comes from the PHY address.
// RULE_13: Scrambler stage serialises five-bit code-groups.
// RULE_14: Scrambled bits feed an NRZI converter producing the serial stream.
// RULE_15: MLT-3 steps to next level on bit 1, holds on bit 0.
// RULE_16: All serial transmit logic runs on the single line clock.
// RULE_17: Transmit error during a frame replaces data with /H/.
// RULE_18: Scrambler is the 11-bit x^11+x^9+1 sequence XORed with the stream.
`timescale 1ns/1ps
module ftx_coder (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [4:0] phy_addr_i,
  input wire ftx_pkg::ftx_mii_tx_s mii_tx_i,
  input wire logic lpi_req_i,
  input wire logic [4:0] rx_code_i,
  input wire logic rx_code_vld_i,
  output logic tx_take_o,
  output logic tx_ser_o,
  output logic tx_nrzi_o,
  output logic [1:0] tx_mlt3_o,
  output ftx_pkg::ftx_mii_rx_s mii_rx_o,
  output logic rx_lpi_o
);
  function automatic logic [4:0] enc(input logic [3:0] n);
    logic [4:0] c;
    c = ftx_pkg::C_IDLE;
    case (n)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      4'hF: c = 5'h1D;
      default: c = ftx_pkg::C_IDLE;
    endcase
    return c;
  endfunction : enc

  function automatic ftx_pkg::ftx_dec_s dec(input logic [4:0] c);
    ftx_pkg::ftx_dec_s r;
    logic [4:0] i;
    r = '0;
    for (int k = 0; k < 16; k++) begin
      i = enc(k[3:0]);
      if (i == c) begin
        r.ok = 1'b1;
        r.nib = k[3:0];
      end
    end
    return r;
  endfunction : dec

  function automatic logic is_invalid(input logic [4:0] c);
    ftx_pkg::ftx_dec_s r;
    r = dec(c);
    return !r.ok && c != ftx_pkg::C_IDLE && c != ftx_pkg::C_J && c != ftx_pkg::C_K &&
           c != ftx_pkg::C_T && c != ftx_pkg::C_R && c != ftx_pkg::C_H && c != ftx_pkg::C_P;
  endfunction : is_invalid

  // PHY address strap, two-flop synchronised
  logic [4:0] addr_s1_q;
  logic [4:0] addr_s2_q;
  logic [2:0] init_q;
  logic seeded;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_s1_q <= 5'h00;
      addr_s2_q <= 5'h00;
    end else begin
      addr_s1_q <= phy_addr_i;
      addr_s2_q <= addr_s1_q;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      init_q <= 3'h0;
    end else if (!seeded) begin
      init_q <= init_q + 3'h1;
    end
  end
  assign seeded = (init_q == ftx_pkg::SEED_SETTLE);

  // Transmit code-group sequencer; one code-group per five clocks
  ftx_pkg::ftx_tx_st_e st_q;
  ftx_pkg::ftx_tx_st_e st_d;
  logic [2:0] cnt_q;
  logic [4:0] sh_q;
  logic [4:0] code_q;
  logic [4:0] code_d;
  logic slot_end;
  assign slot_end = (cnt_q == ftx_pkg::SLOT_LAST);

  always_comb begin
    st_d = st_q;
    case (st_q)
      ftx_pkg::TX_IDLE: st_d = mii_tx_i.en ? ftx_pkg::TX_J : ftx_pkg::TX_IDLE; // RULE_04
      ftx_pkg::TX_J: st_d = ftx_pkg::TX_K; // RULE_04
      ftx_pkg::TX_K,
      ftx_pkg::TX_DATA: st_d = mii_tx_i.en ? ftx_pkg::TX_DATA : ftx_pkg::TX_T; // RULE_05
      ftx_pkg::TX_T: st_d = ftx_pkg::TX_R; // RULE_05
      ftx_pkg::TX_R: st_d = mii_tx_i.en ? ftx_pkg::TX_J : ftx_pkg::TX_IDLE; // RULE_03
      default: st_d = ftx_pkg::TX_IDLE;
    endcase
  end

  always_comb begin
    case (st_d)
      ftx_pkg::TX_IDLE: code_d = lpi_req_i ? ftx_pkg::C_P : ftx_pkg::C_IDLE; // RULE_10
      ftx_pkg::TX_J: code_d = ftx_pkg::C_J;
      ftx_pkg::TX_K: code_d = ftx_pkg::C_K;
      ftx_pkg::TX_DATA: code_d = mii_tx_i.er ? ftx_pkg::C_H : enc(mii_tx_i.d); // RULE_17
      ftx_pkg::TX_T: code_d = ftx_pkg::C_T;
      ftx_pkg::TX_R: code_d = ftx_pkg::C_R;
      default: code_d = ftx_pkg::C_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= ftx_pkg::TX_IDLE;
      cnt_q <= 3'h0;
      code_q <= ftx_pkg::C_IDLE;
    end else if (slot_end) begin
      st_q <= st_d;
      cnt_q <= 3'h0;
      code_q <= code_d; // RULE_01
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // Nibble consumed at each J, K or data slot; J and K replace preamble
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_take_o <= 1'b0;
    end else begin
      tx_take_o <= slot_end && (st_d == ftx_pkg::TX_J || st_d == ftx_pkg::TX_K ||
                                st_d == ftx_pkg::TX_DATA);
    end
  end

  // Parallel-in serial-out, leftmost code bit first
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sh_q <= ftx_pkg::C_IDLE;
    end else if (slot_end) begin
      sh_q <= code_d; // RULE_13
    end else begin
      sh_q <= {sh_q[3:0], 1'b0}; // RULE_13
    end
  end

  // Scrambler; held at its seed until the strap has settled
  logic [10:0] lfsr_q;
  logic fb;
  logic scr_bit;
  assign fb = lfsr_q[10] ^ lfsr_q[8]; // RULE_18
  assign scr_bit = sh_q[4] ^ fb; // RULE_18
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lfsr_q <= 11'h001;
    end else if (!seeded) begin
      // Low bit forced high so an all-zero address still gives a live sequence
      lfsr_q <= {addr_s2_q, ~addr_s2_q, 1'b1}; // RULE_12
    end else begin
      lfsr_q <= {lfsr_q[9:0], fb}; // RULE_18
    end
  end

  // NRZI and MLT-3; every line bit is a single clock
  logic [1:0] mlt_prev_q;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_ser_o <= 1'b0;
      tx_nrzi_o <= 1'b0;
      tx_mlt3_o <= ftx_pkg::MLT_ZERO;
      mlt_prev_q <= ftx_pkg::MLT_NEG;
    end else begin
      tx_ser_o <= scr_bit; // RULE_16
      tx_nrzi_o <= tx_nrzi_o ^ scr_bit; // RULE_14
      if (scr_bit) begin
        // Sequence 0, +, 0, -: leaving zero goes opposite to the last peak
        if (tx_mlt3_o == ftx_pkg::MLT_ZERO) begin
          tx_mlt3_o <= (mlt_prev_q == ftx_pkg::MLT_NEG) ? ftx_pkg::MLT_POS : ftx_pkg::MLT_NEG; // RULE_15
        end else begin
          mlt_prev_q <= tx_mlt3_o;
          tx_mlt3_o <= ftx_pkg::MLT_ZERO; // RULE_15
        end
      end
    end
  end

  // Receive decoder
  ftx_pkg::ftx_rx_st_e rst_q;
  ftx_pkg::ftx_dec_s rdec;
  assign rdec = dec(rx_code_i);
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_q <= ftx_pkg::RX_IDLE;
      mii_rx_o <= '0;
      rx_lpi_o <= 1'b0;
    end else begin
      mii_rx_o.er <= 1'b0;
      rx_lpi_o <= 1'b0;
      if (rx_code_vld_i) begin
        case (rst_q)
          ftx_pkg::RX_IDLE: begin
            if (rx_code_i == ftx_pkg::C_J) begin
              rst_q <= ftx_pkg::RX_GOT_J;
              mii_rx_o.crs <= 1'b1;
              mii_rx_o.d <= ftx_pkg::NIB_SSD; // RULE_06
            end else if (rx_code_i == ftx_pkg::C_K || rx_code_i == ftx_pkg::C_T ||
                         rx_code_i == ftx_pkg::C_R) begin
              mii_rx_o.er <= 1'b1; // RULE_07
            end else if (rx_code_i == ftx_pkg::C_P) begin
              rx_lpi_o <= 1'b1; // RULE_11
            end
          end
          ftx_pkg::RX_GOT_J: begin
            if (rx_code_i == ftx_pkg::C_K) begin
              rst_q <= ftx_pkg::RX_DATA;
              mii_rx_o.dv <= 1'b1;
              mii_rx_o.d <= ftx_pkg::NIB_SSD; // RULE_07
            end else begin
              rst_q <= ftx_pkg::RX_IDLE;
              mii_rx_o.crs <= 1'b0;
              mii_rx_o.er <= 1'b1; // RULE_07
              mii_rx_o.d <= ftx_pkg::NIB_BAD_SSD;
            end
          end
          ftx_pkg::RX_DATA: begin
            if (rdec.ok) begin
              mii_rx_o.d <= rdec.nib;
            end else if (rx_code_i == ftx_pkg::C_T) begin
              rst_q <= ftx_pkg::RX_GOT_T;
              mii_rx_o.dv <= 1'b0;
            end else begin
              // Invalid, /H/, lone /R/ and any other control inside a frame
              mii_rx_o.er <= 1'b1; // RULE_09
            end
          end
          ftx_pkg::RX_GOT_T: begin
            rst_q <= ftx_pkg::RX_IDLE;
            mii_rx_o.crs <= 1'b0; // RULE_08
            mii_rx_o.er <= (rx_code_i != ftx_pkg::C_R); // RULE_08
          end
          default: rst_q <= ftx_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_ssd_order: assert property ($rose(st_q == ftx_pkg::TX_J) |-> // RULE_04
    code_q == ftx_pkg::C_J ##5 code_q == ftx_pkg::C_K)
    else $error("start pair not J then K");
  a_esd_order: assert property ($rose(st_q == ftx_pkg::TX_T) |-> // RULE_05
    code_q == ftx_pkg::C_T ##5 code_q == ftx_pkg::C_R)
    else $error("end pair not T then R");
  a_idle_after_r: assert property (st_q == ftx_pkg::TX_R && slot_end && !mii_tx_i.en // RULE_03
    && !lpi_req_i |=> code_q == ftx_pkg::C_IDLE [*5])
    else $error("idle missing after end pair");
  // Shifter holds a whole code-group only at the slot start; later it carries fill zeros
  a_never_invalid: assert property (!is_invalid(code_q) // RULE_09
    && (cnt_q != 3'h0 || !is_invalid(sh_q)))
    else $error("invalid code-group queued");
  a_data_map: assert property (slot_end && st_d == ftx_pkg::TX_DATA && !mii_tx_i.er // RULE_01
    |=> code_q == enc($past(mii_tx_i.d)))
    else $error("data nibble encoded wrongly");
  a_err_sub: assert property (slot_end && st_d == ftx_pkg::TX_DATA && mii_tx_i.er // RULE_17
    |=> code_q == ftx_pkg::C_H)
    else $error("transmit error not replaced by H");
  a_sleep_sent: assert property (slot_end && st_d == ftx_pkg::TX_IDLE && lpi_req_i // RULE_10
    |=> sh_q == ftx_pkg::C_P)
    else $error("sleep code not sent");
  a_mlt3_step: assert property ($past(tx_ser_o) == 1'b0 ##1 tx_ser_o == 1'b0 // RULE_15
    |-> $stable(tx_mlt3_o) && $stable(tx_nrzi_o))
    else $error("line level moved on a zero bit");
  a_mlt3_move: assert property (tx_ser_o && seeded |-> tx_mlt3_o != $past(tx_mlt3_o)) // RULE_15
    else $error("line level held on a one bit");
  a_seed_live: assert property (seeded |-> lfsr_q != 11'h000) // RULE_12
    else $error("scrambler stuck at zero");
  a_k_lone: assert property (rx_code_vld_i && rx_code_i == ftx_pkg::C_K // RULE_07
    && rst_q != ftx_pkg::RX_GOT_J |=> mii_rx_o.er)
    else $error("lone K not flagged");
  a_esd_end: assert property (rx_code_vld_i && rst_q == ftx_pkg::RX_GOT_T // RULE_08
    |=> !mii_rx_o.crs && !mii_rx_o.dv && (mii_rx_o.er == ($past(rx_code_i) != ftx_pkg::C_R)))
    else $error("end of stream mishandled");
  a_rx_lpi: assert property (rx_code_vld_i && rx_code_i == ftx_pkg::C_P // RULE_11
    && rst_q == ftx_pkg::RX_IDLE |=> rx_lpi_o)
    else $error("far-end sleep not recognised");

  c_frame: cover property (st_q == ftx_pkg::TX_DATA ##[1:200] st_q == ftx_pkg::TX_R);
  c_rx_frame: cover property (mii_rx_o.dv ##[1:200] !mii_rx_o.crs);
  c_bad_ssd: cover property (mii_rx_o.er && mii_rx_o.d == ftx_pkg::NIB_BAD_SSD);
  c_sleep: cover property (code_q == ftx_pkg::C_P);
endmodule : ftx_coder

/* File: ftx_mac_model.sv */
// Behavioural host MAC feeding nibbles to the transmit coder
`timescale 1ns/1ps
module ftx_mac_model (
  input wire logic clk_i,
  input wire logic take_i,
  output ftx_pkg::ftx_mii_tx_s tx_o
);
  initial begin
    tx_o = '{en: 1'b0, er: 1'b0, d: 4'hA};
  end

  // Nibble i carries the low four bits of i; er marks slot er_at
  task automatic frame(input int n, input int er_at);
    int k;
    for (int i = 0; i < n; i++) begin
      tx_o = '{en: 1'b1, er: (i == er_at), d: i[3:0]};
      k = 0;
      do begin
        @(negedge clk_i);
        k++;
      end while (take_i !== 1'b1 && k < 12);
    end
    // Stale nibble inverted so it is never mistaken for data
    tx_o = '{en: 1'b0, er: 1'b0, d: ~tx_o.d};
  endtask : frame
endmodule : ftx_mac_model

/* File: ftx_coder_bench.sv */
// Self-checking bench for the line coder and receive decoder
`timescale 1ns/1ps
module ftx_coder_bench;
  localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [4:0] phy_addr_i = 5'h01;
  logic lpi_req_i = 1'b0;
  logic [4:0] rx_code_i = 5'h1F;
  logic rx_code_vld_i = 1'b0;
  ftx_pkg::ftx_mii_tx_s mii_tx;
  ftx_pkg::ftx_mii_rx_s mii_rx;
  logic tx_take;
  logic tx_ser;
  logic tx_nrzi;
  logic rx_lpi;
  logic [1:0] tx_mlt3;
  logic nrzi_q;
  logic [1:0] lvl;
  logic last_pos;
  logic pl[$];
  logic ks[$];
  int cyc;
  int takes;
  int errors = 0;
  int checks = 0;

  ftx_coder ftx_coder_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .phy_addr_i(phy_addr_i),
    .mii_tx_i(mii_tx), .lpi_req_i(lpi_req_i), .rx_code_i(rx_code_i),
    .rx_code_vld_i(rx_code_vld_i), .tx_take_o(tx_take), .tx_ser_o(tx_ser),
    .tx_nrzi_o(tx_nrzi), .tx_mlt3_o(tx_mlt3), .mii_rx_o(mii_rx), .rx_lpi_o(rx_lpi));
  ftx_mac_model ftx_mac_model_inst (.clk_i(mclk_i), .take_i(tx_take), .tx_o(mii_tx));

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [6:0] got, input logic [6:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Line monitor; keystream learnt from idle 1s, then predicted by its recurrence
  always @(negedge mclk_i) begin
    if (!rstn_i) begin
      cyc = 0;
      takes = 0;
      nrzi_q = 1'b0;
      lvl = ftx_pkg::MLT_ZERO;
      last_pos = 1'b0;
      pl.delete();
      ks.delete();
    end else begin
      cyc++;
      takes += (tx_take === 1'b1);
      if (tx_ser === 1'b1) begin
        nrzi_q = ~nrzi_q;
        last_pos = (lvl === ftx_pkg::MLT_ZERO) ? ~last_pos : last_pos;
        lvl = (lvl !== ftx_pkg::MLT_ZERO) ? ftx_pkg::MLT_ZERO
          : (last_pos ? ftx_pkg::MLT_POS : ftx_pkg::MLT_NEG);
      end
      chk({6'h00, tx_nrzi}, {6'h00, nrzi_q}, "nrzi");
      chk({5'h00, tx_mlt3}, {5'h00, lvl}, "mlt3");
      if (cyc >= 20) begin
        ks.push_back(ks.size() < 11 ? ~tx_ser : ks[ks.size() - 11] ^ ks[ks.size() - 9]);
        pl.push_back(tx_ser ^ ks[ks.size() - 1]);
      end
    end
  end

  task automatic rst(input logic [4:0] addr);
    @(negedge mclk_i);
    rstn_i = 1'b0;
    phy_addr_i = addr;
    repeat (16) @(negedge mclk_i);
    rstn_i = 1'b1;
    repeat (60) @(negedge mclk_i);
  endtask : rst

  task automatic seed_test();
    logic [21:0] a;
    logic [21:0] b;
    rst(5'h01);
    for (int i = 0; i < 22; i++) a[i] = ks[i];
    rst(5'h1E);
    for (int i = 0; i < 22; i++) b[i] = ks[i];
    checks++;
    if (a === b) begin
      errors++;
      $display("ERROR %0t same keystream for two addresses", $time);
    end
    $display("Test seed done");
  endtask : seed_test

  task automatic tx_frame(input int n, input int er_at);
    logic [4:0] exp[$];
    logic [4:0] g;
    int p;
    int t0;
    p = pl.size();
    t0 = takes;
    exp = '{ftx_pkg::C_J, ftx_pkg::C_K};
    for (int i = 2; i < n; i++) exp.push_back(i == er_at ? ftx_pkg::C_H : ENC[i % 16]);
    exp = {exp, ftx_pkg::C_T, ftx_pkg::C_R, ftx_pkg::C_IDLE, ftx_pkg::C_IDLE};
    ftx_mac_model_inst.frame(n, er_at);
    repeat (40) @(negedge mclk_i);
    // First 0 after idle is the third bit of the start group
    while (p < pl.size() && pl[p] === 1'b1) p++;
    p -= 2;
    foreach (exp[j]) begin
      g = {pl[p], pl[p + 1], pl[p + 2], pl[p + 3], pl[p + 4]};
      p += 5;
      chk({2'h0, g}, {2'h0, exp[j]}, "code-group");
    end
    t0 = takes - t0;
    chk(t0[6:0], n[6:0], "nibbles taken");
    $display("Test tx_frame %0d done", n);
  endtask : tx_frame

  task automatic rx_send(input logic [4:0] code, input logic [2:0] st, input logic [3:0] d,
      input logic use_d);
    rx_code_i = code;
    rx_code_vld_i = 1'b1;
    @(negedge mclk_i);
    chk({mii_rx.dv, mii_rx.er, mii_rx.crs, use_d ? mii_rx.d : d}, {st, d}, "rx");
  endtask : rx_send

  task automatic rx_tests();
    rx_send(ftx_pkg::C_J, 3'h1, ftx_pkg::NIB_SSD, 1'b1);
    rx_send(ftx_pkg::C_K, 3'h5, ftx_pkg::NIB_SSD, 1'b1);
    rx_send(5'h1E, 3'h5, 4'h0, 1'b1);
    rx_send(ftx_pkg::C_T, 3'h1, 4'h0, 1'b0);
    rx_send(ftx_pkg::C_R, 3'h0, 4'h0, 1'b0);
    rx_send(5'h06, 3'h0, 4'h0, 1'b0);
    rx_send(ftx_pkg::C_P, 3'h0, 4'h0, 1'b0);
    chk({6'h00, rx_lpi}, 7'h01, "sleep seen");
    rx_send(ftx_pkg::C_J, 3'h1, ftx_pkg::NIB_SSD, 1'b1);
    rx_send(5'h09, 3'h2, ftx_pkg::NIB_BAD_SSD, 1'b1);
    rx_send(ftx_pkg::C_K, 3'h2, 4'h0, 1'b0);
    rx_send(ftx_pkg::C_R, 3'h2, 4'h0, 1'b0);
    rx_send(ftx_pkg::C_J, 3'h1, ftx_pkg::NIB_SSD, 1'b1);
    rx_send(ftx_pkg::C_K, 3'h5, ftx_pkg::NIB_SSD, 1'b1);
    rx_send(ftx_pkg::C_T, 3'h1, 4'h0, 1'b0);
    rx_send(5'h09, 3'h2, 4'h0, 1'b0);
    rx_send(ftx_pkg::C_J, 3'h1, ftx_pkg::NIB_SSD, 1'b1);
    rx_send(ftx_pkg::C_K, 3'h5, ftx_pkg::NIB_SSD, 1'b1);
    rx_code_i = 5'h19;
    @(negedge mclk_i);
    chk({6'h00, mii_rx.er}, 7'h01, "invalid in frame");
    rx_code_vld_i = 1'b0;
    rx_code_i = 5'h0A;
    @(negedge mclk_i);
    chk({6'h00, mii_rx.er}, 7'h00, "error pulse width");
    $display("Test rx done");
  endtask : rx_tests

  task automatic lpi_test();
    int z;
    lpi_req_i = 1'b1;
    repeat (40) @(negedge mclk_i);
    z = 0;
    for (int i = 1; i <= 20; i++) z += (pl[pl.size() - i] === 1'b0);
    chk(z[6:0], 7'h14, "sleep code on line");
    lpi_req_i = 1'b0;
    $display("Test lpi done");
  endtask : lpi_test

  task automatic summarize();
    $display("Checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  initial begin
    seed_test();
    tx_frame(18, -1);
    tx_frame(5, 3);
    rx_tests();
    lpi_test();
    summarize();
  end

  // Whole run is about four hundred cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end
endmodule : ftx_coder_bench
